// ==== inc/ref_prio_pkg.sv ====
// Register map, reset values and field layout for the reference priority bank.
// Assumes an 8-bit register port clocked by the device system clock.
package ref_prio_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRIO_W = 4;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned IDX_W = 2;
  // =========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] PRIORITY_INPUTS_ONE_TWO_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] PRIORITY_INPUTS_THREE_FOUR_ADDR = 8'h19;
  // =========================================================
  // Reset values, per path
  localparam logic [DATA_W-1:0] MAIN_ONE_TWO_RST = 8'h32;
  localparam logic [DATA_W-1:0] MAIN_THREE_FOUR_RST = 8'h54;
  localparam logic [DATA_W-1:0] SEC_ONE_TWO_RST = 8'h00;
  localparam logic [DATA_W-1:0] SEC_THREE_FOUR_RST = 8'h00;
  // =========================================================
  // Field layout
  localparam int unsigned LO_NIBBLE_LSB = 0;
  localparam int unsigned HI_NIBBLE_LSB = 4;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 4'h0;
  localparam logic [PRIO_W-1:0] PRIO_WORST = 4'hf;
endpackage

// ==== src/ref_input_priority_regs.sv ====
// Priority table for input references one to four, two banks (main, secondary).
// Assumes the register port and the path bank select come from same-clock logic.
// =========================================================
// Behaviour
// RULE1 - Register 0x18 holds input two priority high nibble, input one low nibble.
// RULE2 - Register 0x19 holds input four priority high nibble, input three low nibble.
// RULE3 - A smaller priority number ranks as more preferred.
// RULE4 - Priority zero excludes the input; one to fifteen make it eligible.
// RULE5 - Bank select low: accesses reach the main timing path set.
// RULE6 - Bank select high: accesses reach the secondary timing path set.
// RULE7 - Registers read/write; main resets 0x32/0x54, secondary resets to zero.
// RULE8 - Select lowest nonzero priority per path; ties go to lowest input.
module ref_input_priority_regs
  import ref_prio_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_path_bank_select,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_main_valid,
  output logic [IDX_W-1:0] o_main_sel,
  output logic o_sec_valid,
  output logic [IDX_W-1:0] o_sec_sel
);

  // =========================================================
  // Address and bank decode
  logic hit_12;
  logic hit_34;
  logic wr_main;
  logic wr_sec;
  logic wr_main_12;
  logic wr_main_34;
  logic wr_sec_12;
  logic wr_sec_34;

  assign hit_12 = (i_addr == PRIORITY_INPUTS_ONE_TWO_ADDR);
  assign hit_34 = (i_addr == PRIORITY_INPUTS_THREE_FOUR_ADDR);
  assign wr_main = i_wr_en && !i_path_bank_select; // [RULE5]
  assign wr_sec = i_wr_en && i_path_bank_select; // [RULE6]
  assign wr_main_12 = wr_main && hit_12; // [RULE1]
  assign wr_main_34 = wr_main && hit_34; // [RULE2]
  assign wr_sec_12 = wr_sec && hit_12; // [RULE1]
  assign wr_sec_34 = wr_sec && hit_34; // [RULE2]

  // =========================================================
  // Storage, one byte per address and path
  logic [DATA_W-1:0] main_12_q;
  logic [DATA_W-1:0] main_34_q;
  logic [DATA_W-1:0] sec_12_q;
  logic [DATA_W-1:0] sec_34_q;

  prio_pair_reg #(
    .WIDTH(DATA_W),
    .RESET_VALUE(MAIN_ONE_TWO_RST)
  ) u_main_12 (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(wr_main_12),
    .i_wdata(i_wdata),
    .o_value(main_12_q)
  ); // [RULE7]

  prio_pair_reg #(
    .WIDTH(DATA_W),
    .RESET_VALUE(MAIN_THREE_FOUR_RST)
  ) u_main_34 (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(wr_main_34),
    .i_wdata(i_wdata),
    .o_value(main_34_q)
  ); // [RULE7]

  prio_pair_reg #(
    .WIDTH(DATA_W),
    .RESET_VALUE(SEC_ONE_TWO_RST)
  ) u_sec_12 (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(wr_sec_12),
    .i_wdata(i_wdata),
    .o_value(sec_12_q)
  ); // [RULE7]

  prio_pair_reg #(
    .WIDTH(DATA_W),
    .RESET_VALUE(SEC_THREE_FOUR_RST)
  ) u_sec_34 (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(wr_sec_34),
    .i_wdata(i_wdata),
    .o_value(sec_34_q)
  ); // [RULE7]

  // =========================================================
  // Read path, registered one cycle; unmapped addresses read zero
  logic [DATA_W-1:0] bank_12;
  logic [DATA_W-1:0] bank_34;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_d;

  assign bank_12 = i_path_bank_select ? sec_12_q : main_12_q; // [RULE5] [RULE6]
  assign bank_34 = i_path_bank_select ? sec_34_q : main_34_q; // [RULE5] [RULE6]
  assign rd_mux = hit_12 ? bank_12 : (hit_34 ? bank_34 : '0);
  // Read data holds until the next read, so idle cycles never disturb it
  assign rdata_d = i_rd_en ? rd_mux : o_rdata;

  // =========================================================
  // Nibbles flattened per path, input one in the lowest bits
  logic [NUM_INPUTS*PRIO_W-1:0] main_flat;
  logic [NUM_INPUTS*PRIO_W-1:0] sec_flat;

  assign main_flat = {main_34_q[HI_NIBBLE_LSB +: PRIO_W], // [RULE2]
                      main_34_q[LO_NIBBLE_LSB +: PRIO_W], // [RULE2]
                      main_12_q[HI_NIBBLE_LSB +: PRIO_W], // [RULE1]
                      main_12_q[LO_NIBBLE_LSB +: PRIO_W]}; // [RULE1]
  assign sec_flat = {sec_34_q[HI_NIBBLE_LSB +: PRIO_W], // [RULE2]
                     sec_34_q[LO_NIBBLE_LSB +: PRIO_W], // [RULE2]
                     sec_12_q[HI_NIBBLE_LSB +: PRIO_W], // [RULE1]
                     sec_12_q[LO_NIBBLE_LSB +: PRIO_W]}; // [RULE1]

  // =========================================================
  // Selection, one picker per path
  logic main_found;
  logic [IDX_W-1:0] main_idx;
  logic sec_found;
  logic [IDX_W-1:0] sec_idx;

  prio_pick u_main_pick (
    .i_prio_flat(main_flat),
    .o_found(main_found),
    .o_idx(main_idx)
  ); // [RULE8]

  prio_pick u_sec_pick (
    .i_prio_flat(sec_flat),
    .o_found(sec_found),
    .o_idx(sec_idx)
  ); // [RULE8]

  // =========================================================
  // Output registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
      o_main_valid <= 1'b0;
      o_main_sel <= '0;
      o_sec_valid <= 1'b0;
      o_sec_sel <= '0;
    end else begin
      o_rdata <= rdata_d;
      o_main_valid <= main_found; // [RULE8]
      o_main_sel <= main_idx;
      o_sec_valid <= sec_found; // [RULE8]
      o_sec_sel <= sec_idx;
    end
  end

endmodule // ref_input_priority_regs

// =========================================================
// One byte of priority storage with its own reset value
module prio_pair_reg
  import ref_prio_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_value
);

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_value <= RESET_VALUE; // [RULE7]
    end else if (i_load) begin
      o_value <= i_wdata; // [RULE7]
    end
  end

endmodule // prio_pair_reg

// =========================================================
// Lowest nonzero priority picker
module prio_pick
  import ref_prio_pkg::*;
#(
  parameter int unsigned N = NUM_INPUTS,
  parameter int unsigned PW = PRIO_W,
  parameter int unsigned IW = IDX_W
) (
  input wire logic [N*PW-1:0] i_prio_flat,
  output logic o_found,
  output logic [IW-1:0] o_idx
);

  logic [PW-1:0] best;
  logic [PW-1:0] cand;

  // Strict less-than keeps the earlier input on a tie
  always_comb begin
    o_found = 1'b0;
    o_idx = '0;
    best = PW'(PRIO_WORST);
    cand = '0;
    for (int i = 0; i < N; i++) begin
      cand = i_prio_flat[i*PW +: PW];
      if (cand != PW'(PRIO_DISABLED) && (!o_found || cand < best)) begin // [RULE3] [RULE4]
        o_found = 1'b1;
        best = cand;
        o_idx = IW'(i); // [RULE8]
      end
    end
  end

endmodule // prio_pick

// ==== tb/ref_input_priority_regs_props.sv ====
// Checker on the priority bank ports.
// Assumes one clock, synchronous low reset.
module prio_props import ref_prio_pkg::*; (
  input logic i_ref_clk,
  input logic i_resetn,
  input logic i_path_bank_select,
  input logic [7:0] i_addr,
  input logic i_wr_en,
  input logic i_rd_en,
  input logic [7:0] o_rdata,
  input logic o_main_valid,
  input logic [1:0] o_main_sel,
  input logic o_sec_valid,
  input logic [1:0] o_sec_sel
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire [5:0] sel = {o_main_valid, o_main_sel, o_sec_valid, o_sec_sel};
  wire mw = i_wr_en & !i_path_bank_select, sw = i_wr_en & i_path_bank_select;
  a_rd_hold: assert property (!i_rd_en |=> $stable(o_rdata)) else $error("rdata");
  a_rd_unmap: assert property (i_rd_en && i_addr[7:1] != 7'h0c |=> !o_rdata)
    else $error("unmapped");
  a_main_off: assert property (!sel[5] |-> !sel[4:3]) else $error("main sel");
  a_sec_off: assert property (!sel[2] |-> !sel[1:0]) else $error("sec sel");
  a_rst_sel: assert property ($rose(i_resetn) |=> sel[5:2] == 4'h8) else $error("rst");
  a_main_keep: assert property ((i_resetn && !mw) [*2] |=> $stable(sel[5:3]))
    else $error("main");
  a_sec_keep: assert property ((i_resetn && !sw) [*2] |=> $stable(sel[2:0]))
    else $error("sec");
  a_sel_quiet: assert property ((i_resetn && !i_wr_en) [*2] |=> $stable(sel))
    else $error("sel");
endmodule // prio_props
bind ref_input_priority_regs prio_props props (.*);

// ==== tb/ref_input_priority_regs_bench.sv ====
// Bench: register calls with expected values.
// Assumes bank select is a same-clock input.
module ref_input_priority_regs_bench import ref_prio_pkg::*; ;
  timeunit 1ns/1ns;
  logic i_ref_clk = 0, i_resetn = 0, i_path_bank_select = 0, i_wr_en = 0, i_rd_en = 0;
  logic o_main_valid, o_sec_valid;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
  logic [1:0] o_main_sel, o_sec_sel;
  int fail_count = 0, checks_done = 0;
  ref_input_priority_regs uut (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_path_bank_select(i_path_bank_select),
    .i_addr(i_addr),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_main_valid(o_main_valid),
    .o_main_sel(o_main_sel),
    .o_sec_valid(o_sec_valid),
    .o_sec_sel(o_sec_sel)
  );
  initial forever #50 i_ref_clk = ~i_ref_clk;
  task automatic op(input logic b, w, input logic [7:0] a, d, s);
    @(posedge i_ref_clk);
    {i_path_bank_select,i_wr_en,i_rd_en,i_addr,i_wdata} <= {b,w,!w,a,d};
    @(posedge i_ref_clk);
    {i_wr_en, i_rd_en} <= 2'b00;
    @(posedge i_ref_clk);
    #1 checks_done++;
    if ({o_main_valid,o_main_sel,o_sec_valid,o_sec_sel} !== s[5:0] || !w && o_rdata !== d) begin
      fail_count++;
      $display("unexpected at %0t: %h", $time, a);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    op(0,0,8'h18,8'h32,8'h20);
    op(0,0,8'h19,8'h54,8'h20);
    op(1,0,8'h1a,8'h00,8'h20);
    op(1,1,8'h19,8'h20,8'h27);
    op(1,1,8'h18,8'h32,8'h24);
    op(0,1,8'h18,8'h00,8'h34);
    op(1,0,8'h18,8'h32,8'h34);
    op(0,0,8'h19,8'h54,8'h34);
    op(0,1,8'h19,8'h00,8'h04);
    op(0,0,8'h18,8'h00,8'h04);
    @(posedge i_ref_clk) i_resetn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    op(0,0,8'h18,8'h32,8'h20);
    op(1,0,8'h19,8'h00,8'h20);
    op(1,1,8'h19,8'hf0,8'h27);
    finish_test();
  end
endmodule // ref_input_priority_regs_bench
